// ### logic/lmsc_bank.sv
/*
  Lane marker, filler and scrambler configuration bank with datapath use.
  Assumes management requests arrive synchronous to ref_clk, one per cycle.
*/
// What this block does
// - Window register 0x1F accesses pointed extended register
// - Tx match character at 0x8000, reset 2BC
// - Tx substitute character at 0x8001, reset 27C
// - Rx match character at 0x8002, reset 27C
// - Rx substitute character at 0x8003, reset 2BC
// - Tx marker swap only when 0x1D bit7
// - Rx marker swap only when 0x1D bit11
// - Tx positive filler at 0x8004, reset 2BC
// - Tx negative filler at 0x8005, reset 2BC
// - Rx positive filler at 0x8006, reset 2BC
// - Rx negative filler at 0x8007, reset 2BC
// - Enable bit1 scrambles 20-bit post-encode words
// - Enable bit0 scrambles 16-bit pre-encode words
// - Scrambler enable register resets to FC00
// - Seed from 0x800C upper, 0x800D lower
// - Seed lower bit 0 always zero
// - Polynomial upper half at 0x800E, reset 0
// - Polynomial lower at 0x800F, reset C0, bit0 zero
`timescale 1ns/1ps
`default_nettype none
module lmsc_bank (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire lmsc_pkg::lmsc_req_t mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire lmsc_pkg::lmsc_data_t data_in,
  output var lmsc_pkg::lmsc_data_t data_out,
  output logic [9:0] tx_filler_pos,
  output logic [9:0] tx_filler_neg,
  output logic [9:0] rx_filler_pos,
  output logic [9:0] rx_filler_neg
);
  import lmsc_pkg::*;

  typedef struct packed {
    logic [15:0] ptr;
    logic [15:0] ctrl1;
    logic [9:0] tx_match;
    logic [9:0] tx_subst;
    logic [9:0] rx_match;
    logic [9:0] rx_subst;
    logic [9:0] tx_fp;
    logic [9:0] tx_fn;
    logic [9:0] rx_fp;
    logic [9:0] rx_fn;
    logic [15:0] scr_en;
    logic [15:0] seed_hi;
    logic [15:0] seed_lo;
    logic [15:0] poly_hi;
    logic [15:0] poly_lo;
    logic [15:0] rdata;
    logic rvalid;
    logic [9:0] tx_char;
    logic [9:0] rx_char;
  } lmsc_st_t;

  lmsc_st_t st_ff;
  lmsc_st_t nxt_st;
  logic [15:0] ext_rd;
  logic [31:0] seed_value;
  logic [31:0] poly_value;
  logic [LMSC_PRE_W-1:0] pre_q;
  logic [LMSC_POST_W-1:0] post_q;

  // extended register read decode
  function automatic logic [15:0] ext_read(input lmsc_st_t s, input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      LMSC_X_TX_MATCH: r = {6'h00, s.tx_match};
      LMSC_X_TX_SUBST: r = {6'h00, s.tx_subst};
      LMSC_X_RX_MATCH: r = {6'h00, s.rx_match};
      LMSC_X_RX_SUBST: r = {6'h00, s.rx_subst};
      LMSC_X_TX_FILL_P: r = {6'h00, s.tx_fp};
      LMSC_X_TX_FILL_N: r = {6'h00, s.tx_fn};
      LMSC_X_RX_FILL_P: r = {6'h00, s.rx_fp};
      LMSC_X_RX_FILL_N: r = {6'h00, s.rx_fn};
      LMSC_X_SCR_EN: r = s.scr_en;
      LMSC_X_SEED_HI: r = s.seed_hi;
      LMSC_X_SEED_LO: r = s.seed_lo;
      LMSC_X_POLY_HI: r = s.poly_hi;
      LMSC_X_POLY_LO: r = s.poly_lo;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : ext_read

  assign ext_rd = ext_read(st_ff, st_ff.ptr);
  assign seed_value = {st_ff.seed_hi, st_ff.seed_lo};
  assign poly_value = {st_ff.poly_hi, st_ff.poly_lo};

  always_comb begin
    logic [15:0] w;
    w = mgmt_req.wdata;
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (mgmt_req.req && !mgmt_req.wr) begin
      nxt_st.rvalid = 1'b1;
      case (mgmt_req.addr)
        LMSC_ADDR_CTRL1: nxt_st.rdata = st_ff.ctrl1;
        LMSC_ADDR_PTR: nxt_st.rdata = st_ff.ptr;
        LMSC_ADDR_WINDOW: nxt_st.rdata = ext_rd;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    if (mgmt_req.req && mgmt_req.wr) begin
      case (mgmt_req.addr)
        LMSC_ADDR_CTRL1: nxt_st.ctrl1 = w;
        LMSC_ADDR_PTR: nxt_st.ptr = w;
        LMSC_ADDR_WINDOW: begin
          case (st_ff.ptr)
            LMSC_X_TX_MATCH: nxt_st.tx_match = w[9:0];
            LMSC_X_TX_SUBST: nxt_st.tx_subst = w[9:0];
            LMSC_X_RX_MATCH: nxt_st.rx_match = w[9:0];
            LMSC_X_RX_SUBST: nxt_st.rx_subst = w[9:0];
            LMSC_X_TX_FILL_P: nxt_st.tx_fp = w[9:0];
            LMSC_X_TX_FILL_N: nxt_st.tx_fn = w[9:0];
            LMSC_X_RX_FILL_P: nxt_st.rx_fp = w[9:0];
            LMSC_X_RX_FILL_N: nxt_st.rx_fn = w[9:0];
            LMSC_X_SCR_EN: nxt_st.scr_en = w;
            LMSC_X_SEED_HI: nxt_st.seed_hi = w;
            LMSC_X_SEED_LO: nxt_st.seed_lo = {w[15:1], 1'b0};
            LMSC_X_POLY_HI: nxt_st.poly_hi = w;
            LMSC_X_POLY_LO: nxt_st.poly_lo = {w[15:1], 1'b0};
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // marker swap, one character per cycle per direction
    nxt_st.tx_char = data_in.tx_char;
    if (st_ff.ctrl1[LMSC_BIT_TX_MARK_EN] && data_in.tx_char == st_ff.tx_match) begin
      nxt_st.tx_char = st_ff.tx_subst;
    end
    nxt_st.rx_char = data_in.rx_char;
    if (st_ff.ctrl1[LMSC_BIT_RX_MARK_EN] && data_in.rx_char == st_ff.rx_match) begin
      nxt_st.rx_char = st_ff.rx_subst;
    end
  end

  // the pre-encode scrambler sees the seed too; a zero seed is software's problem
  lmsc_lfsr #(.W(LMSC_PRE_W)) u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .enable(st_ff.scr_en[LMSC_BIT_PRE_SCR]),
    .seed(seed_value),
    .poly(poly_value),
    .din(data_in.pre_word),
    .dout(pre_q)
  );

  lmsc_lfsr #(.W(LMSC_POST_W)) u_post (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .enable(st_ff.scr_en[LMSC_BIT_POST_SCR]),
    .seed(seed_value),
    .poly(poly_value),
    .din(data_in.post_word),
    .dout(post_q)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff.ptr <= LMSC_RST_PTR;
      st_ff.ctrl1 <= LMSC_RST_CTRL1;
      st_ff.tx_match <= LMSC_RST_CHAR_A;
      st_ff.tx_subst <= LMSC_RST_CHAR_B;
      st_ff.rx_match <= LMSC_RST_CHAR_B;
      st_ff.rx_subst <= LMSC_RST_CHAR_A;
      st_ff.tx_fp <= LMSC_RST_CHAR_A;
      st_ff.tx_fn <= LMSC_RST_CHAR_A;
      st_ff.rx_fp <= LMSC_RST_CHAR_A;
      st_ff.rx_fn <= LMSC_RST_CHAR_A;
      st_ff.scr_en <= LMSC_RST_SCR_EN;
      st_ff.seed_hi <= LMSC_RST_SEED_HI;
      st_ff.seed_lo <= LMSC_RST_SEED_LO;
      st_ff.poly_hi <= LMSC_RST_POLY_HI;
      st_ff.poly_lo <= LMSC_RST_POLY_LO;
      st_ff.rdata <= 16'h0000;
      st_ff.rvalid <= 1'b0;
      st_ff.tx_char <= 10'h000;
      st_ff.rx_char <= 10'h000;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign mgmt_rdata = st_ff.rdata;
  assign mgmt_rvalid = st_ff.rvalid;
  // one driver for the whole carrier, fields in struct order
  assign data_out = {st_ff.tx_char, st_ff.rx_char, pre_q, post_q};
  assign tx_filler_pos = st_ff.tx_fp;
  assign tx_filler_neg = st_ff.tx_fn;
  assign rx_filler_pos = st_ff.rx_fp;
  assign rx_filler_neg = st_ff.rx_fn;
endmodule : lmsc_bank
`default_nettype wire

// ### logic/lmsc_lfsr.sv
/*
  Programmable 32-bit scrambler: taps are the set polynomial bits,
  seed loaded while disabled. Assumes caller holds word stable per strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module lmsc_lfsr #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [31:0] seed,
  input wire logic [31:0] poly,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import lmsc_pkg::*;

  typedef struct packed {
    logic [31:0] state;
    logic [W-1:0] out;
  } lmsc_lfsr_st_t;

  lmsc_lfsr_st_t st_ff;
  lmsc_lfsr_st_t nxt_st;

  // one serial step per data bit, unrolled by the loop
  always_comb begin
    logic [31:0] s;
    logic fb;
    s = st_ff.state;
    fb = 1'b0;
    nxt_st = st_ff;
    if (!enable) begin
      nxt_st.state = seed;
      nxt_st.out = din;
    end else begin
      for (int i = 0; i < W; i++) begin
        fb = ^(s & poly);
        nxt_st.out[i] = din[i] ^ s[31];
        s = {s[30:0], fb};
      end
      nxt_st.state = s;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.out;
endmodule : lmsc_lfsr
`default_nettype wire

// ### logic/lmsc_pkg.sv
/*
  Package for the lane marker and scrambler configuration bank:
  register addresses, reset values, field positions and carrier structs.
  Assumes a 16-bit clause 22 style register access port.
*/
`default_nettype none
package lmsc_pkg;
  localparam logic [4:0] LMSC_ADDR_CTRL1 = 5'h1D;
  localparam logic [4:0] LMSC_ADDR_PTR = 5'h1E;
  localparam logic [4:0] LMSC_ADDR_WINDOW = 5'h1F;

  localparam logic [15:0] LMSC_X_TX_MATCH = 16'h8000;
  localparam logic [15:0] LMSC_X_TX_SUBST = 16'h8001;
  localparam logic [15:0] LMSC_X_RX_MATCH = 16'h8002;
  localparam logic [15:0] LMSC_X_RX_SUBST = 16'h8003;
  localparam logic [15:0] LMSC_X_TX_FILL_P = 16'h8004;
  localparam logic [15:0] LMSC_X_TX_FILL_N = 16'h8005;
  localparam logic [15:0] LMSC_X_RX_FILL_P = 16'h8006;
  localparam logic [15:0] LMSC_X_RX_FILL_N = 16'h8007;
  localparam logic [15:0] LMSC_X_SCR_EN = 16'h8009;
  localparam logic [15:0] LMSC_X_SEED_HI = 16'h800C;
  localparam logic [15:0] LMSC_X_SEED_LO = 16'h800D;
  localparam logic [15:0] LMSC_X_POLY_HI = 16'h800E;
  localparam logic [15:0] LMSC_X_POLY_LO = 16'h800F;

  localparam logic [15:0] LMSC_RST_PTR = 16'h0000;
  localparam logic [15:0] LMSC_RST_CTRL1 = 16'h0880;
  localparam logic [9:0] LMSC_RST_CHAR_A = 10'h2BC;
  localparam logic [9:0] LMSC_RST_CHAR_B = 10'h27C;
  localparam logic [15:0] LMSC_RST_SCR_EN = 16'hFC00;
  localparam logic [15:0] LMSC_RST_SEED_HI = 16'h0000;
  localparam logic [15:0] LMSC_RST_SEED_LO = 16'h01FC;
  localparam logic [15:0] LMSC_RST_POLY_HI = 16'h0000;
  localparam logic [15:0] LMSC_RST_POLY_LO = 16'h00C0;

  localparam int LMSC_BIT_TX_MARK_EN = 7;
  localparam int LMSC_BIT_RX_MARK_EN = 11;
  localparam int LMSC_BIT_POST_SCR = 1;
  localparam int LMSC_BIT_PRE_SCR = 0;
  localparam int LMSC_CHAR_W = 10;
  localparam int LMSC_POST_W = 20;
  localparam int LMSC_PRE_W = 16;

  typedef struct packed {
    logic req;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } lmsc_req_t;

  typedef struct packed {
    logic [9:0] tx_char;
    logic [9:0] rx_char;
    logic [LMSC_PRE_W-1:0] pre_word;
    logic [LMSC_POST_W-1:0] post_word;
  } lmsc_data_t;
endpackage : lmsc_pkg
`default_nettype wire

// ### sim/lmsc_asserts.sv
/* port checker for lmsc_bank, bound below.
   assumes one clock, async active high rst. */
`timescale 1ns/1ps
`default_nettype none
module lmsc_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire lmsc_pkg::lmsc_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire lmsc_pkg::lmsc_data_t data_in,
  input wire lmsc_pkg::lmsc_data_t data_out
);
  import lmsc_pkg::*;
  logic [15:0] ptr_ff;
  logic [2:0] en_ff;
  logic rd, wrt, rdw;
  assign rd = ce && mgmt_req.req && !mgmt_req.wr;
  assign wrt = ce && mgmt_req.req && mgmt_req.wr;
  assign rdw = rd && mgmt_req.addr == LMSC_ADDR_WINDOW;
  // shadow of pointer and enables, same timing as the bank
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= 16'h0000;
      en_ff <= 3'h3;
    end else if (wrt) begin
      if (mgmt_req.addr == LMSC_ADDR_PTR) ptr_ff <= mgmt_req.wdata;
      if (mgmt_req.addr == LMSC_ADDR_CTRL1) en_ff[1:0] <= {mgmt_req.wdata[11], mgmt_req.wdata[7]};
      if (mgmt_req.addr == LMSC_ADDR_WINDOW && ptr_ff == LMSC_X_SCR_EN) en_ff[2] <= mgmt_req.wdata[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RVALID_ON: assert property (rd |=> mgmt_rvalid) else $error("read not answered");
  AST_RVALID_OFF: assert property (ce && !rd |=> !mgmt_rvalid) else $error("answer without read");
  AST_CHAR_UPPER: assert property (rdw && ptr_ff[15:3] == 13'h1000 |=> mgmt_rdata[15:10] == 6'h00)
    else $error("char register upper bits set");
  AST_BIT0_ZERO: assert property (
    rdw && (ptr_ff == LMSC_X_SEED_LO || ptr_ff == LMSC_X_POLY_LO) |=> !mgmt_rdata[0])
    else $error("seed or poly bit0 set");
  AST_UNMAPPED: assert property (rdw && (!ptr_ff[15] || ptr_ff == 16'h8008) |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_TX_PASS: assert property (ce && !en_ff[0] |=> data_out.tx_char == $past(data_in.tx_char))
    else $error("tx char altered while off");
  AST_RX_PASS: assert property (ce && !en_ff[1] |=> data_out.rx_char == $past(data_in.rx_char))
    else $error("rx char altered while off");
  AST_PRE_PASS: assert property (ce && !en_ff[2] |=> data_out.pre_word == $past(data_in.pre_word))
    else $error("pre word altered while off");
  cover property (rdw && ptr_ff == LMSC_X_SEED_LO);
  cover property (ce && en_ff[2]);
  cover property (ce && !en_ff[0]);
endmodule : lmsc_asserts
bind lmsc_bank lmsc_asserts u_chk (.ref_clk, .rst, .ce, .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .data_in, .data_out);
`default_nettype wire

// ### sim/lmsc_station.sv
/* management station model for the clause 22 port.
   assumes tasks are entered 1 ns after a rising edge, ce high. */
`timescale 1ns/1ps
`default_nettype none
module lmsc_station (
  input wire logic ref_clk,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  output var lmsc_pkg::lmsc_req_t mgmt_req
);
  import lmsc_pkg::*;
  initial mgmt_req = '0;
  task automatic put(input logic w, input logic [4:0] a, input logic [15:0] d);
    mgmt_req = '{1'b1, w, a, d};
    @(posedge ref_clk);
    #1;
  endtask : put
  // released lines show junk, never the old request
  task automatic drop();
    mgmt_req = {1'b0, ~mgmt_req[21:0]};
  endtask : drop
  task automatic wr22(input logic [4:0] a, input logic [15:0] d);
    put(1'b1, a, d);
    drop();
    // idle edge so the next request never lands in the step of the drop
    @(posedge ref_clk);
    #1;
  endtask : wr22
  task automatic rd22(input logic [4:0] a, output logic [15:0] d, output logic ok);
    put(1'b0, a, 16'h0000);
    drop();
    ok = 1'b0;
    d = 16'h0000;
    repeat (4) begin
      if (!ok) begin
        ok = (mgmt_rvalid === 1'b1);
        d = mgmt_rdata;
        @(posedge ref_clk);
        #1;
      end
    end
  endtask : rd22
  task automatic ext_wr(input logic [15:0] x, input logic [15:0] d);
    put(1'b1, LMSC_ADDR_PTR, x);
    wr22(LMSC_ADDR_WINDOW, d);
  endtask : ext_wr
  task automatic ext_rd(input logic [15:0] x, output logic [15:0] d, output logic ok);
    put(1'b1, LMSC_ADDR_PTR, x);
    rd22(LMSC_ADDR_WINDOW, d, ok);
  endtask : ext_rd
endmodule : lmsc_station
`default_nettype wire

// ### sim/tb_top.sv
/* bench for lmsc_bank: station model reaches registers, bench drives data.
   assumes package, bank, station and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import lmsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  lmsc_req_t mgmt_req;
  logic [15:0] mgmt_rdata, e_pre;
  logic mgmt_rvalid;
  lmsc_data_t data_in = '0;
  lmsc_data_t data_out;
  logic [9:0] fill [4];
  logic [19:0] e_post;
  logic [31:0] seed, poly, s_pre, s_post;
  int fails = 0;
  int checks_done = 0;
  localparam logic [15:0] XA [13] = '{16'h8000, 16'h8001, 16'h8002, 16'h8003, 16'h8004, 16'h8005, 16'h8006,
    16'h8007, 16'h8009, 16'h800C, 16'h800D, 16'h800E, 16'h800F};
  localparam logic [15:0] RV [13] = '{16'h02BC, 16'h027C, 16'h027C, 16'h02BC, 16'h02BC, 16'h02BC, 16'h02BC,
    16'h02BC, 16'hFC00, 16'h0000, 16'h01FC, 16'h0000, 16'h00C0};
  always #10 ref_clk = ~ref_clk;
  lmsc_station st (.ref_clk, .mgmt_rdata, .mgmt_rvalid, .mgmt_req);
  lmsc_bank dut (.ref_clk, .rst, .ce, .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .data_in, .data_out,
    .tx_filler_pos(fill[0]), .tx_filler_neg(fill[1]), .rx_filler_pos(fill[2]), .rx_filler_neg(fill[3]));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic rd(input logic ext, input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    if (ext) st.ext_rd(a, d, ok);
    else st.rd22(a[4:0], d, ok);
    if (!ok) begin
      fails++;
      tally_and_finish();
    end else begin
      `CHK(d, e)
    end
  endtask : rd
  task automatic dp(input logic [9:0] t, input logic [9:0] r, input logic [9:0] et, input logic [9:0] er);
    data_in.tx_char = t;
    data_in.rx_char = r;
    @(posedge ref_clk);
    #1;
    `CHK(data_out.tx_char, et)
    `CHK(data_out.rx_char, er)
  endtask : dp
  // reference scrambler, low bit first
  function automatic logic [19:0] scr(input logic [19:0] w, input int n, inout logic [31:0] s);
    logic [19:0] o;
    o = w;
    for (int i = 0; i < n; i++) begin
      o[i] = w[i] ^ s[31];
      s = {s[30:0], ^(s & poly)};
    end
    return o;
  endfunction : scr
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(1'b0, 16'h001E, 16'h0000);
    rd(1'b0, 16'h001D, 16'h0880);
    for (int i = 0; i < 4; i++) begin
      `CHK(fill[i], 10'h2BC)
    end
    for (int i = 0; i < 13; i++) begin
      rd(1'b1, XA[i], RV[i]);
    end
    dp(10'h2BC, 10'h27C, 10'h27C, 10'h2BC);
    dp(10'h155, 10'h0AA, 10'h155, 10'h0AA);
    st.wr22(5'h1D, 16'h0000);
    dp(10'h2BC, 10'h27C, 10'h2BC, 10'h27C);
    st.wr22(5'h1D, 16'h0880);
    st.ext_wr(16'h8000, 16'h0155);
    dp(10'h155, 10'h2BC, 10'h27C, 10'h2BC);
    st.ext_wr(16'h8008, 16'h1234);
    rd(1'b1, 16'h8008, 16'h0000);
    rd(1'b0, 16'h0003, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      st.ext_wr(XA[i], 16'hFFFF);
      rd(1'b1, XA[i], i < 8 ? 16'h03FF : (i == 10 || i == 12) ? 16'hFFFE : 16'hFFFF);
    end
    for (int i = 0; i < 4; i++) begin
      `CHK(fill[i], 10'h3FF)
    end
    // clock enable low: the whole write must be lost
    ce = 1'b0;
    st.ext_wr(16'h8004, 16'h0123);
    ce = 1'b1;
    rd(1'b1, 16'h8004, 16'h03FF);
    `CHK(fill[0], 10'h3FF)
    seed = 32'h12345678;
    poly = 32'h04000080;
    st.ext_wr(16'h8009, 16'hFC00);
    st.ext_wr(16'h800C, 16'h1234);
    st.ext_wr(16'h800D, 16'h5679);
    st.ext_wr(16'h800E, 16'h0400);
    st.ext_wr(16'h800F, 16'h0081);
    data_in.pre_word = 16'hA5A5;
    data_in.post_word = 20'h0F0F0;
    st.ext_wr(16'h8009, 16'hFC03);
    s_pre = seed;
    s_post = seed;
    // first scrambled word is already out when the write returns
    repeat (3) begin
      e_pre = 16'(scr(20'h0A5A5, 16, s_pre));
      e_post = scr(20'h0F0F0, 20, s_post);
      `CHK(data_out.pre_word, e_pre)
      `CHK(data_out.post_word, e_post)
      @(posedge ref_clk);
      #1;
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
